/* File: src/kbd_host_port.sv */
// Purpose: host mailbox, status flags, interrupts and fast gate/reset port
// Assumes: host and controller strobes are one-cycle pulses on clk_sys
// Notes:   rst_n is the host bus reset, the only hardware reset
`timescale 1ns/1ps
`default_nettype none

module kbd_host_port
  import kbd_port_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [HOST_ADDR_W-1:0] hostAddr,
  input  wire logic                   hostWr,
  input  wire logic                   hostRd,
  input  wire logic [7:0]             hostWrData,
  output var  logic [7:0]             hostRdData,
  output var  logic                   hostAck,
  input  wire logic                   cpuWr,
  input  wire logic [7:0]             cpuWrData,
  input  wire logic                   cpuRd,
  output var  logic [7:0]             cpuRdData,
  input  wire logic                   cpuStatusWr,
  input  wire logic [7:0]             cpuStatusWrData,
  output var  logic [7:0]             cpuStatus,
  input  wire logic                   enFlags,
  input  wire logic                   ctlPortKirqBit,
  input  wire logic                   ctlPortAirqBit,
  input  wire logic                   ctlPortGateBit,
  input  wire logic                   ctlResetN,
  input  wire logic                   fastGateEnable,
  input  wire logic                   kbdResetPolarity,
  output var  logic                   kbdIrqOut,
  output var  logic                   auxIrqOut,
  output var  logic                   ctlGateLine,
  output var  logic                   alternateGateLine,
  output var  logic                   alternateResetN,
  output var  logic                   kbdResetOut,
  input  wire logic [PIN_COUNT-1:0]   pinCtl,
  input  wire logic [PIN_COUNT-1:0]   pinIn,
  output var  logic [PIN_COUNT-1:0]   pinOut,
  output var  logic [PIN_COUNT-1:0]   pinOe,
  output var  logic [PIN_COUNT-1:0]   pinSense
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] outData;
  logic       gateA20Bit;
  logic       gateRstBit;

  alt_pulse_if tmr ();

  // ----------------------------------------------------------------------
  // host address decode
  // ----------------------------------------------------------------------
  wire dataSel  = (hostAddr == MAILBOX_DATA_ADDR);
  wire cmdSel   = (hostAddr == MAILBOX_CMD_ADDR);
  wire gateSel  = (hostAddr == FAST_GATE_ADDR) && fastGateEnable;
  wire anySel   = dataSel | cmdSel | gateSel;

  wire hostMbWr  = hostWr & (dataSel | cmdSel);
  wire hostObfRd = hostRd & dataSel;
  wire gateWr    = hostWr & gateSel;

  // ----------------------------------------------------------------------
  // status flags; a set in the same cycle as its clear wins
  // ----------------------------------------------------------------------
  wire out_buffer_full = cpuStatus[ST_OBF];
  wire in_buffer_full = cpuStatus[ST_IBF];

  wire next_obf = cpuWr | (out_buffer_full & ~hostObfRd);
  wire next_ibf = hostMbWr | (in_buffer_full & ~cpuRd);
  wire next_cmd = hostMbWr ? hostAddr[HOST_ADDR_CMD_BIT]
                           : cpuStatus[ST_CMD];

  wire [7:0] userBits = cpuStatusWr ? (cpuStatusWrData & USER_MASK)
                                    : (cpuStatus & USER_MASK);

  wire [7:0] flagBits = (8'h01 << ST_OBF) & {8{next_obf}}
                      | (8'h01 << ST_IBF) & {8{next_ibf}}
                      | (8'h01 << ST_CMD) & {8{next_cmd}};

  wire [7:0] next_status = userBits | flagBits;

  // ----------------------------------------------------------------------
  // fast gate register view
  // ----------------------------------------------------------------------
  wire [7:0] gateView = FG_FIXED_ONES
                      | ({7'h00, gateA20Bit} << FG_GATE_BIT)
                      | ({7'h00, gateRstBit} << FG_RESET_BIT);

  // a pulse starts only on a 0 to 1 change of bit 0
  wire pulseReq = gateWr & hostWrData[FG_RESET_BIT] & ~gateRstBit;
  assign tmr.trigger = pulseReq;

  // ----------------------------------------------------------------------
  // host read mux
  // ----------------------------------------------------------------------
  wire [7:0] hostRdValue = dataSel ? outData   :
                           cmdSel  ? cpuStatus :
                           gateSel ? gateView  : 8'h00;

  // ----------------------------------------------------------------------
  // output combinations
  // ----------------------------------------------------------------------
  wire next_kbd_irq_out = enFlags ? (ctlPortKirqBit & next_obf)
                           : ctlPortKirqBit;
  wire next_airq = enFlags ? (ctlPortAirqBit & ~next_ibf)
                           : ctlPortAirqBit;

  // enabled pulse merged with the controller's own reset request
  wire mergedRstN = ctlResetN & ~(fastGateEnable & tmr.pulseLow);
  wire next_kbdReset = mergedRstN ^ kbdResetPolarity;

  // ----------------------------------------------------------------------
  // mailbox registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpuStatus <= STATUS_RESET;
      outData   <= 8'h00;
      cpuRdData <= 8'h00;
    end else begin
      cpuStatus <= next_status;
      if (cpuWr) outData <= cpuWrData;
      if (hostMbWr) cpuRdData <= hostWrData;
    end
  end

  // ----------------------------------------------------------------------
  // host answer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hostRdData <= 8'h00;
      hostAck    <= 1'b0;
    end else begin
      hostAck <= (hostRd | hostWr) & anySel;
      if (hostRd && anySel) hostRdData <= hostRdValue;
    end
  end

  // ----------------------------------------------------------------------
  // fast gate register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gateA20Bit <= FAST_GATE_RESET[FG_GATE_BIT];
      gateRstBit <= FAST_GATE_RESET[FG_RESET_BIT];
    end else if (gateWr) begin
      gateA20Bit <= hostWrData[FG_GATE_BIT];
      gateRstBit <= hostWrData[FG_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kbdIrqOut         <= 1'b0;
      auxIrqOut         <= 1'b0;
      ctlGateLine       <= 1'b0;
      alternateGateLine <= 1'b0;
      alternateResetN   <= 1'b1;
      kbdResetOut       <= 1'b1;
    end else begin
      kbdIrqOut         <= next_kbd_irq_out;
      auxIrqOut         <= next_airq;
      ctlGateLine       <= ctlPortGateBit;
      alternateGateLine <= gateA20Bit;
      alternateResetN   <= ~tmr.pulseLow;
      kbdResetOut       <= next_kbdReset;
    end
  end

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  // each count rounded up to whole cycles from its own documented minimum
  alt_reset_timer #(
    .DELAY_CYC (ALT_RST_DELAY_CYC),
    .WIDTH_CYC (ALT_RST_WIDTH_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tmr     (tmr.timer)
  );

  kbd_pin_bank #(
    .PINS (PIN_COUNT)
  ) u_pins (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .portBits (pinCtl),
    .pinIn    (pinIn),
    .pinOut   (pinOut),
    .pinOe    (pinOe),
    .pinSense (pinSense)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // fall is due 274 cycles after the eight high samples
  localparam int PULSE_LO = 272;
  localparam int PULSE_HI = 276;

  // helper: length of the current low pulse on alternateResetN
  logic [15:0] lowCnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) lowCnt <= 16'h0000;
    else if (!alternateResetN) lowCnt <= lowCnt + 16'h0001;
    else lowCnt <= 16'h0000;
  end

  chk_obf_on_write:
    assert property (cpuWr |=> out_buffer_full && outData == $past(cpuWrData))
    else $error("out-full or data not loaded by controller write");

  chk_kbd_irq_out_follow:
    assert property (cpuWr && enFlags && ctlPortKirqBit ##1
                     (enFlags && ctlPortKirqBit && !hostObfRd)
                     |=> kbdIrqOut)
    else $error("keyboard irq did not follow out-full");

  chk_kbd_irq_out_forced:
    assert property ((enFlags && !ctlPortKirqBit)[*2] |-> !kbdIrqOut)
    else $error("keyboard irq not forced low");

  chk_host_write:
    assert property (hostMbWr |=> in_buffer_full && cpuRdData == $past(hostWrData)
                     && cpuStatus[ST_CMD] == $past(hostAddr[2]))
    else $error("host write did not set flags or byte");

  chk_ibf_clear:
    assert property (cpuRd && !hostMbWr |=> !in_buffer_full ##1
                     (!$past(enFlags) || !$past(ctlPortAirqBit) ||
                      $past(hostMbWr) || auxIrqOut))
    else $error("in-full not cleared or aux irq not restored");

  chk_obf_clear:
    assert property (hostObfRd && !cpuWr |=> !out_buffer_full)
    else $error("host data read did not clear out-full");

  chk_user_write:
    assert property (cpuStatusWr && !cpuWr && !hostObfRd |=>
                     (cpuStatus & USER_MASK) ==
                     ($past(cpuStatusWrData) & USER_MASK) && 
                     out_buffer_full == $past(out_buffer_full))
    else $error("user bits or flags wrong after status write");

  chk_gate_ignored:
    assert property (hostWr && hostAddr == FAST_GATE_ADDR &&
                     !fastGateEnable |=> !hostAck && $stable(gateA20Bit))
    else $error("fast gate register answered while disabled");

  chk_gate_level:
    assert property (gateWr |-> ##2 alternateGateLine ==
                     $past(hostWrData[FG_GATE_BIT], 2))
    else $error("alternate gate line does not match written bit");

  chk_pulse_delay:
    assert property (pulseReq |=> alternateResetN[*8] ##[PULSE_LO:PULSE_HI]
                     $fell(alternateResetN))
    else $error("alternate reset pulse delay out of range");

  chk_pulse_width:
    assert property ($rose(alternateResetN) |->
                     lowCnt >= 16'(ALT_RST_WIDTH_CYC))
    else $error("alternate reset pulse too short");

  chk_kbd_reset:
    assert property (!ctlResetN && !kbdResetPolarity |=> !kbdResetOut)
    else $error("controller reset not passed to keyboard reset");

  chk_airq_follow:
    assert property (enFlags && ctlPortAirqBit |=> auxIrqOut == !in_buffer_full)
    else $error("aux irq does not carry inverted in-full");

  chk_airq_direct:
    assert property (!enFlags |=> auxIrqOut == $past(ctlPortAirqBit))
    else $error("aux irq does not follow its port bit");

  chk_data_read:
    assert property (hostObfRd |=> hostAck &&
                     hostRdData == $past(outData))
    else $error("host data read did not return the loaded byte");

  chk_status_read:
    assert property (hostRd && cmdSel |=> hostAck &&
                     hostRdData == $past(cpuStatus))
    else $error("host status read did not return status");

  chk_host_no_user:
    assert property (hostMbWr && !cpuStatusWr |=>
                     (cpuStatus & USER_MASK) == $past(cpuStatus & USER_MASK))
    else $error("host write changed user status bits");

  chk_cmd_kept:
    assert property (!hostMbWr |=>
                     cpuStatus[ST_CMD] == $past(cpuStatus[ST_CMD]))
    else $error("command flag changed without a host write");

  chk_obf_kept:
    assert property (!cpuWr && !hostObfRd |=>
                     out_buffer_full == $past(out_buffer_full))
    else $error("out-full changed without write or host read");

  chk_kbd_pulse:
    assert property (fastGateEnable && tmr.pulseLow |=>
                     kbdResetOut == $past(kbdResetPolarity))
    else $error("enabled alternate pulse not merged into keyboard reset");

  chk_gate_read:
    assert property (hostRd && gateSel |=> hostAck &&
                     hostRdData == $past(gateView))
    else $error("fast gate register read returned wrong value");

endmodule : kbd_host_port
`default_nettype wire

/* File: src/kbd_port_pkg.sv */
// Purpose: shared constants of the keyboard host port and fast gate logic
// Assumes: 20 MHz system clock, 16-bit host I/O addresses
// Notes:   offsets, field positions, reset values and cycle counts live here
package kbd_port_pkg;

  // ----------------------------------------------------------------------
  // host i/o map
  // ----------------------------------------------------------------------
  localparam int          HOST_ADDR_W       = 16;
  localparam logic [15:0] MAILBOX_DATA_ADDR = 16'h0060;
  localparam logic [15:0] MAILBOX_CMD_ADDR  = 16'h0064;
  localparam logic [15:0] FAST_GATE_ADDR    = 16'h0092;
  localparam int          HOST_ADDR_CMD_BIT = 2;

  // ----------------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------------
  localparam int         ST_OBF       = 0;
  localparam int         ST_IBF       = 1;
  localparam int         ST_CMD       = 3;
  localparam logic [7:0] USER_MASK    = 8'hf4;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // fast gate / reset register
  // ----------------------------------------------------------------------
  localparam logic [7:0] FAST_GATE_RESET = 8'h24;
  localparam logic [7:0] FG_FIXED_ONES   = 8'h24;
  localparam int         FG_GATE_BIT     = 1;
  localparam int         FG_RESET_BIT    = 0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int ALT_RST_DELAY_NS  = 14000;
  localparam int ALT_RST_WIDTH_NS  = 6000;
  localparam int ALT_RST_DELAY_CYC =
    (ALT_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALT_RST_WIDTH_CYC =
    (ALT_RST_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CLKS   = 24;
  localparam int PIN_COUNT         = 4;

endpackage : kbd_port_pkg

/* File: src/alt_pulse_if.sv */
// Purpose: trigger and pulse state between fast gate logic and its timer
// Assumes: single clock domain
// Notes:   trigger is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface alt_pulse_if;
  logic trigger;
  logic pulseLow;
  modport ctl   (output trigger, input pulseLow);
  modport timer (input trigger, output pulseLow);
endinterface : alt_pulse_if
`default_nettype wire

/* File: src/alt_reset_timer.sv */
// Purpose: delayed fixed-width pulse for the alternate cpu reset
// Assumes: trigger only while idle is acted upon
// Notes:   counts run on clk_sys directly, no divider needed
`timescale 1ns/1ps
`default_nettype none
module alt_reset_timer
  import kbd_port_pkg::*;
#(
  parameter int DELAY_CYC = ALT_RST_DELAY_CYC,
  parameter int WIDTH_CYC = ALT_RST_WIDTH_CYC
) (
  input wire logic         clk_sys,
  input wire logic         rst_n,
  alt_pulse_if.timer       tmr
);
  localparam int CNT_W = $clog2((DELAY_CYC > WIDTH_CYC ?
                                 DELAY_CYC : WIDTH_CYC) + 1);

  if (DELAY_CYC < 1 || WIDTH_CYC < 1) begin : g_bad_cfg
    $error("alt_reset_timer: counts must be at least one cycle");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_PULSE = 3'b100
  } tstate_t;

  tstate_t          state;
  logic [CNT_W-1:0] cnt;

  wire cntDone = (cnt == '0);
  assign tmr.pulseLow = (state == ST_PULSE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: if (tmr.trigger) begin
          state <= ST_WAIT;
          cnt   <= CNT_W'(DELAY_CYC - 1);
        end
        ST_WAIT: if (cntDone) begin
          state <= ST_PULSE;
          cnt   <= CNT_W'(WIDTH_CYC - 1);
        end else cnt <= cnt - 1'b1;
        ST_PULSE: if (cntDone) state <= ST_IDLE;
                  else cnt <= cnt - 1'b1;
      endcase
    end
  end
endmodule : alt_reset_timer
`default_nettype wire

/* File: src/kbd_pin_bank.sv */
// Purpose: open-drain keyboard and aux pins driven from controller port bits
// Assumes: a port bit of 1 pulls its pin low (pin is the inverted bit)
// Notes:   enable low means driving; all pins pulled low under reset
`timescale 1ns/1ps
`default_nettype none
module kbd_pin_bank
  import kbd_port_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic [PINS-1:0] portBits,
  input  wire logic [PINS-1:0] pinIn,
  output var  logic [PINS-1:0] pinOut,
  output var  logic [PINS-1:0] pinOe,
  output var  logic [PINS-1:0] pinSense
);
  if (PINS < 1) begin : g_bad_cfg
    $error("kbd_pin_bank: at least one pin");
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pinOut[i]   <= 1'b0;
        pinOe[i]    <= 1'b0;
        pinSense[i] <= 1'b0;
      end else begin
        pinOut[i]   <= 1'b0;
        pinOe[i]    <= ~portBits[i];
        pinSense[i] <= pinIn[i];
      end
    end
  end
endmodule : kbd_pin_bank
`default_nettype wire

/* File: tb/host_cpu_model.sv */
// Purpose: host processor issuing i/o cycles to the keyboard port
// Assumes: strobes are one-cycle pulses, answer one cycle later
// Notes:   idle address and data are inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
  import kbd_port_pkg::*;
(
  input  wire logic                   clk_sys,
  output var  logic [HOST_ADDR_W-1:0] hostAddr,
  output var  logic                   hostWr,
  output var  logic                   hostRd,
  output var  logic [7:0]             hostWrData,
  input  wire logic [7:0]             hostRdData,
  input  wire logic                   hostAck
);
  initial begin
    hostAddr   = 16'hffff;
    hostWr     = 1'b0;
    hostRd     = 1'b0;
    hostWrData = 8'h00;
  end

  // entered just after an edge; strobe spans exactly one sampling edge
  task automatic io_cycle(input logic wr, input logic [15:0] addr,
                          input logic [7:0] wdata, output logic ack,
                          output logic [7:0] rdata);
    hostAddr   = addr;
    hostWrData = wdata;
    hostWr     = wr;
    hostRd     = !wr;
    @(posedge clk_sys);
    #1;
    ack        = hostAck;
    rdata      = hostRdData;
    hostWr     = 1'b0;
    hostRd     = 1'b0;
    hostAddr   = ~addr;
    hostWrData = ~wdata;
    // one idle edge, so a following call never re-raises a strobe at once
    @(posedge clk_sys);
    #1;
  endtask : io_cycle
endmodule : host_cpu_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the keyboard host port
// Assumes: host cycles from host_cpu_model, controller strobes from here
// Notes:   fixed seed; reset pulse timer runs with its full default counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  import kbd_port_pkg::*;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic [HOST_ADDR_W-1:0] hostAddr;
  logic                   hostWr, hostRd, hostAck, ack;
  logic [7:0]             hostWrData, hostRdData, cpuRdData, cpuStatus, rd;
  logic [7:0]             cpuWrData = 8'h00, cpuStatusWrData = 8'h00;
  logic                   cpuWr = 1'b0, cpuRd = 1'b0, cpuStatusWr = 1'b0;
  logic                   enFlags = 1'b0, kirqBit = 1'b0, airqBit = 1'b0;
  logic                   gateBit = 1'b0, ctlResetN = 1'b1, rstPol = 1'b0;
  logic                   fgEn = 1'b0;
  logic                   kbdIrqOut, auxIrqOut, ctlGateLine;
  logic                   alternateGateLine, alternateResetN, kbdResetOut;
  logic [3:0]             pinCtl = 4'h0, pinIn = 4'ha;
  logic [3:0]             pinOut, pinOe, pinSense;
  int                     n_errors = 0, check_count = 0;
  // system glue; the alternate reset stands in for the cpu reset
  wire                    cpuAddrMaskN = ctlGateLine | alternateGateLine |
                                         ~alternateResetN;

  always #25 clk_sys = ~clk_sys;

  kbd_host_port dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .hostAddr(hostAddr),
    .hostWr(hostWr), .hostRd(hostRd), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .hostAck(hostAck), .cpuWr(cpuWr),
    .cpuWrData(cpuWrData), .cpuRd(cpuRd), .cpuRdData(cpuRdData),
    .cpuStatusWr(cpuStatusWr), .cpuStatusWrData(cpuStatusWrData),
    .cpuStatus(cpuStatus), .enFlags(enFlags), .ctlPortKirqBit(kirqBit),
    .ctlPortAirqBit(airqBit), .ctlPortGateBit(gateBit),
    .ctlResetN(ctlResetN), .fastGateEnable(fgEn),
    .kbdResetPolarity(rstPol), .kbdIrqOut(kbdIrqOut),
    .auxIrqOut(auxIrqOut), .ctlGateLine(ctlGateLine),
    .alternateGateLine(alternateGateLine),
    .alternateResetN(alternateResetN), .kbdResetOut(kbdResetOut),
    .pinCtl(pinCtl), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinSense(pinSense)
  );

  host_cpu_model hm (
    .clk_sys(clk_sys), .hostAddr(hostAddr), .hostWr(hostWr),
    .hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostAck(hostAck)
  );

  // ----------------------------------------------------------------------
  // checking and bus helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // kind 0 data write, 1 data read, 2 status write
  task automatic cpu_pulse(input int kind, input logic [7:0] d);
    cpuWr = (kind == 0);
    cpuRd = (kind == 1);
    cpuStatusWr = (kind == 2);
    cpuWrData = d;
    cpuStatusWrData = d;
    tick(1);
    cpuWr = 1'b0;
    cpuRd = 1'b0;
    cpuStatusWr = 1'b0;
    tick(1);
  endtask : cpu_pulse

  task automatic hwr(input logic [15:0] a, input logic [7:0] d);
    hm.io_cycle(1'b1, a, d, ack, rd);
  endtask : hwr

  task automatic hrd(input logic [15:0] a);
    hm.io_cycle(1'b0, a, 8'h00, ack, rd);
  endtask : hrd

  // bounded waits: 500 stands for no edge seen
  task automatic wait_pulse(output int dly, output int wid);
    dly = 0;
    wid = 0;
    while (alternateResetN === 1'b1 && dly < 500) begin
      tick(1);
      dly++;
    end
    while (alternateResetN === 1'b0 && wid < 500) begin
      if (wid == 1) chk_bit("merged reset", rstPol, kbdResetOut);
      tick(1);
      wid++;
    end
  endtask : wait_pulse

  function automatic logic irq_exp(input logic en, input logic bit_,
                                   input logic flag);
    return en ? (bit_ & flag) : bit_;
  endfunction : irq_exp

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0]  d, u;
    logic [15:0] a;
    int          dly, wid, seedInit;
    seedInit = $urandom(69006);
    tick(RESET_HOLD_CLKS);
    chk_byte("status in reset", 8'h00, cpuStatus);
    chk_byte("pin levels in reset", 8'h00, {pinOut, pinOe});
    chk_bit("alt reset idle", 1'b1, alternateResetN);
    chk_bit("alt gate idle", 1'b0, alternateGateLine);
    rst_n = 1'b1;
    tick(1);
    hwr(FAST_GATE_ADDR, 8'h02);
    chk_bit("disabled ack", 1'b0, ack);
    tick(1);
    chk_bit("disabled gate", 1'b0, alternateGateLine);
    hrd(16'h0061);
    chk_bit("unmapped ack", 1'b0, ack);
    fgEn = 1'b1;
    hrd(FAST_GATE_ADDR);
    chk_byte("fast gate reset", 8'h24, rd);
    for (int i = 0; i < 24; i++) begin
      enFlags = 1'($urandom);
      kirqBit = 1'($urandom);
      airqBit = (i < 4) ? 1'b1 : 1'($urandom);
      pinCtl = 4'($urandom);
      pinIn = 4'($urandom);
      u = 8'($urandom);
      cpu_pulse(2, u);
      u = u & USER_MASK;
      chk_bit("flags kept", 1'b0, |cpuStatus[ST_IBF:ST_OBF]);
      chk_byte("pin enables", {4'h0, ~pinCtl}, {pinOut, pinOe});
      chk_byte("pin sense", {4'h0, pinIn}, {4'h0, pinSense});
      d = (i == 0) ? 8'hff : 8'($urandom);
      a = i[0] ? MAILBOX_CMD_ADDR : MAILBOX_DATA_ADDR;
      hwr(a, d);
      chk_bit("write ack", 1'b1, ack);
      chk_byte("cpu data", d, cpuRdData);
      tick(1);
      chk_bit("aux irq full", irq_exp(enFlags, airqBit, 1'b0), auxIrqOut);
      hrd(MAILBOX_CMD_ADDR);
      chk_byte("status read", u | {4'h0, a[2], 3'h2}, rd);
      cpu_pulse(1, 8'h00);
      chk_bit("in full cleared", 1'b0, cpuStatus[ST_IBF]);
      d = 8'($urandom);
      cpu_pulse(0, d);
      chk_bit("out full set", 1'b1, cpuStatus[ST_OBF]);
      tick(1);
      chk_bit("kbd irq set", irq_exp(enFlags, kirqBit, 1'b1), kbdIrqOut);
      chk_bit("aux irq empty", airqBit, auxIrqOut);
      hrd(MAILBOX_DATA_ADDR);
      chk_byte("host data", d, rd);
      chk_bit("out full cleared", 1'b0, cpuStatus[ST_OBF]);
      tick(1);
      chk_bit("kbd irq clear", irq_exp(enFlags, kirqBit, 1'b0), kbdIrqOut);
    end
    for (int b = 0; b < 2; b++) begin
      hwr(FAST_GATE_ADDR, 8'(b * 2));
      tick(1);
      chk_bit("alt gate", 1'(b), alternateGateLine);
      chk_bit("addr mask", 1'(b), cpuAddrMaskN);
      hrd(FAST_GATE_ADDR);
      chk_byte("fast gate read", FG_FIXED_ONES | 8'(b * 2), rd);
    end
    for (int k = 0; k < 4; k++) begin
      {ctlResetN, rstPol} = 2'(k);
      gateBit = 1'(k);
      tick(2);
      chk_bit("kbd reset out", ctlResetN ^ rstPol, kbdResetOut);
      chk_bit("ctl gate", gateBit, ctlGateLine);
    end
    hwr(FAST_GATE_ADDR, 8'h03);
    wait_pulse(dly, wid);
    chk_bit("pulse delay", 1'b1, dly >= ALT_RST_DELAY_CYC);
    chk_bit("pulse width", 1'b1, wid >= ALT_RST_WIDTH_CYC);
    chk_bit("pulse ends", 1'b1, wid < 500);
    hwr(FAST_GATE_ADDR, 8'h03);
    wait_pulse(dly, wid);
    chk_bit("no repeat pulse", 1'b1, dly == 500);
    hwr(FAST_GATE_ADDR, 8'h02);
    hwr(FAST_GATE_ADDR, 8'h03);
    wait_pulse(dly, wid);
    chk_bit("rearmed pulse", 1'b1, dly >= ALT_RST_DELAY_CYC && dly < 500);
    cpu_pulse(2, 8'hff);
    rst_n = 1'b0;
    tick(RESET_HOLD_CLKS);
    chk_byte("status second reset", 8'h00, cpuStatus);
    chk_bit("gate second reset", 1'b0, alternateGateLine);
    rst_n = 1'b1;
    tick(1);
    hrd(FAST_GATE_ADDR);
    chk_byte("fast gate after reset", 8'h24, rd);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("unexpected watchdog expired");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
